/* File: rtl/pap_defines.svh */
// Register offsets, reset values and field positions of the first port
`ifndef PAP_DEFINES_SVH
`define PAP_DEFINES_SVH
// Offsets are word indices; the bus byte address is four times the index
`define PAP_OFF_LATCH     10'h005
`define PAP_OFF_CMP_CTRL  10'h01f
`define PAP_OFF_DIR       10'h085
`define PAP_OFF_VREF_CTRL 10'h09f
`define PAP_OFF_CONFIG    10'h0c0
`define PAP_ADDR_HI       11
`define PAP_IDX_LO        2
`define PAP_BIT_CMP1_PIN  3
`define PAP_LATCH_CLR_HI  3
`define PAP_CMP_WR_HI     5
`define PAP_RST_DIR       8'hff
`define PAP_RST_CTRL      8'h00
`define PAP_RST_LATCH_LO  4'h0
`define PAP_VREF_RSVD_MSK 8'hef
`define PAP_CFG_MASK      8'h07
`define PAP_BIT_OD        4
`define PAP_BIT_IN_ONLY   5
`define PAP_BIT_OSC_OUT   6
`define PAP_BIT_OSC_IN    7
`define PAP_CFG_MASTER_CLEAR_IN      0
`define PAP_CFG_OSC_LO    1
`define PAP_CFG_OSC_HI    2
`define PAP_CMP_MODE_LO   0
`define PAP_CMP_MODE_HI   2
`define PAP_CMP_OUT_MODE  3'h6
`define PAP_CMP1_OUT      6
`define PAP_CMP2_OUT      7
`define PAP_DIV_LAST      2'h3
`define PAP_DIV_HALF      1
`endif

/* File: rtl/pap_pkg.sv */
// Types shared by the first port design
package pap_pkg;
	typedef enum logic [1:0] {
		PAP_OSC_RC       = 2'h0,
		PAP_OSC_INTERNAL = 2'h1,
		PAP_OSC_CRYSTAL  = 2'h2,
		PAP_OSC_EXT_CLK  = 2'h3
	} pap_osc_mode_t;
	typedef enum logic [1:0] {
		PAP_APB_IDLE   = 2'b01,
		PAP_APB_ACCESS = 2'b10
	} pap_apb_state_t;
endpackage : pap_pkg

/* File: rtl/pap_quarter_clock.sv */
// Divide-by-four clock output for the oscillator output pin
`timescale 1ns/1ps
`include "pap_defines.svh"
module pap_quarter_clock
	import pap_pkg::*;
(
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic enable,
	output logic      quarter_clock_out
);
	logic [1:0] count_ff;
	logic       clk_ff;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= 2'h0;
		end else if (!enable) begin
			count_ff <= 2'h0;
		end else begin
			count_ff <= count_ff + 2'h1;
		end
	end

	// Half period of two core cycles
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_ff <= 1'b0;
		end else begin
			clk_ff <= enable & count_ff[`PAP_DIV_HALF];
		end
	end

	assign quarter_clock_out = clk_ff;
endmodule : pap_quarter_clock

/* File: rtl/pap_pin_cell.sv */
// One port pin: output driver, enable and input gating
`timescale 1ns/1ps
`include "pap_defines.svh"
module pap_pin_cell
	import pap_pkg::*;
#(
	parameter bit OPEN_DRAIN = 1'b0,
	parameter bit INPUT_ONLY = 1'b0
) (
	input  wire logic latch_bit,
	input  wire logic dir_bit,
	input  wire logic pin_in,
	input  wire logic taken_over,
	output logic      pin_out,
	output logic      pin_oe_n,
	output logic      read_bit
);
	always_comb begin
		pin_out  = latch_bit;
		pin_oe_n = dir_bit | taken_over;
		if (INPUT_ONLY) begin
			pin_oe_n = 1'b1;
		end else if (OPEN_DRAIN) begin
			pin_out  = 1'b0;
			pin_oe_n = dir_bit | latch_bit;
		end
		read_bit = taken_over ? 1'b0 : pin_in;
	end
endmodule : pap_pin_cell

/* File: rtl/pap_port.sv */
// First port: APB registers, pin functions and reset values
`timescale 1ns/1ps
`include "pap_defines.svh"
// Operation
// - Pin 4 as output only pulls low, never drives high.
// - Configuration bit picks general input or master clear for pin 5.
// - As master clear, pin 5 low holds the device in reset.
// - RC or internal oscillator: pin 6 may output quarter oscillator clock.
// - Latch bits 3:0 clear on reset; bit 4 kept on other resets.
// - Reference bit 4 reads zero; comparator and reference clear on reset.
// - Pin 4 feeds the timer-0 clock input and may carry comparator output.
// - Every reset sets all direction bits to one.
// - Direction one tristates the pin; zero drives the latch value.
// - Port reads give pin levels; writes load the written data into latch.
// - Oscillator-owned pins 6 and 7 read zero, direction ignored.
module pap_port
	import pap_pkg::*;
#(
	parameter int PORT_WIDTH = 8
) (
	input  wire logic                  sys_clk,
	input  wire logic                  rst_n,
	input  wire logic                  por_n,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [`PAP_ADDR_HI:0] paddr,
	input  wire logic [31:0]           pwdata,
	input  wire logic [3:0]            pstrb,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	input  wire logic [PORT_WIDTH-1:0] pad_in,
	output logic      [PORT_WIDTH-1:0] pad_out,
	output logic      [PORT_WIDTH-1:0] pad_oe_n,
	input  wire logic                  cmp1_result,
	input  wire logic                  cmp2_result,
	output logic                       master_clear_req,
	output logic                       timer0_ext_clock,
	output logic      [PORT_WIDTH-1:0] comparator_control,
	output logic      [PORT_WIDTH-1:0] vref_control
);
	logic [PORT_WIDTH-1:0] first_port_latch_ff;
	logic [PORT_WIDTH-1:0] first_port_direction_ff;
	logic [PORT_WIDTH-1:0] cmp_ctrl_ff;
	logic [PORT_WIDTH-1:0] vref_ctrl_ff;
	logic [PORT_WIDTH-1:0] config_ff;
	logic [31:0]           prdata_ff;
	logic [PORT_WIDTH-1:0] pin_read;
	logic [PORT_WIDTH-1:0] raw_out;
	logic [PORT_WIDTH-1:0] raw_oe_n;
	logic [PORT_WIDTH-1:0] taken;
	logic [PORT_WIDTH-1:0] nxt_latch;
	logic                  master_clear_select;
	logic                  osc_owns_pins;
	logic                  clk_out_en;
	logic                  cmp_out_mode;
	logic                  quarter_clock_out;
	logic                  wr_en;
	logic                  rd_en;
	logic                  addr_ok;
	logic                  word_ok;
	logic [`PAP_ADDR_HI:`PAP_IDX_LO] reg_idx;
	pap_osc_mode_t         osc_mode;

	assign master_clear_select = config_ff[`PAP_CFG_MASTER_CLEAR_IN];
	assign osc_mode = pap_osc_mode_t'(config_ff[`PAP_CFG_OSC_HI:`PAP_CFG_OSC_LO]);
	assign osc_owns_pins = (osc_mode == PAP_OSC_CRYSTAL) || (osc_mode == PAP_OSC_EXT_CLK);
	assign clk_out_en = (osc_mode == PAP_OSC_RC) || (osc_mode == PAP_OSC_INTERNAL);
	assign cmp_out_mode = (cmp_ctrl_ff[`PAP_CMP_MODE_HI:`PAP_CMP_MODE_LO] == `PAP_CMP_OUT_MODE);

	// Pins 6 and 7 belong to the oscillator in crystal and external modes
	always_comb begin
		taken = '0;
		taken[`PAP_BIT_OSC_OUT] = osc_owns_pins;
		taken[`PAP_BIT_OSC_IN]  = osc_owns_pins;
	end

	genvar gi;
	generate
		for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_pin
			pap_pin_cell #(
				.OPEN_DRAIN(gi == `PAP_BIT_OD),
				.INPUT_ONLY(gi == `PAP_BIT_IN_ONLY)
			) u_cell (
				.latch_bit (first_port_latch_ff[gi]),
				.dir_bit   (first_port_direction_ff[gi]),
				.pin_in    (pad_in[gi]),
				.taken_over(taken[gi]),
				.pin_out   (raw_out[gi]),
				.pin_oe_n  (raw_oe_n[gi]),
				.read_bit  (pin_read[gi])
			);
		end
	endgenerate

	pap_quarter_clock u_qclk (
		.sys_clk          (sys_clk),
		.rst_n            (rst_n),
		.enable           (clk_out_en),
		.quarter_clock_out(quarter_clock_out)
	);

	// Alternate outputs on pins 3, 4 and 6
	always_comb begin
		pad_out  = raw_out;
		pad_oe_n = raw_oe_n;
		if (cmp_out_mode) begin
			pad_out[`PAP_BIT_CMP1_PIN] = cmp_ctrl_ff[`PAP_CMP1_OUT];
			pad_out[`PAP_BIT_OD] = 1'b0;
			pad_oe_n[`PAP_BIT_OD] = first_port_direction_ff[`PAP_BIT_OD]
				| cmp_ctrl_ff[`PAP_CMP2_OUT];
		end
		if (clk_out_en) begin
			pad_out[`PAP_BIT_OSC_OUT]  = quarter_clock_out;
			pad_oe_n[`PAP_BIT_OSC_OUT] = 1'b0;
		end
	end

	assign timer0_ext_clock = pad_in[`PAP_BIT_OD];
	assign master_clear_req = master_clear_select & ~pad_in[`PAP_BIT_IN_ONLY];

	// Single-cycle APB slave
	assign pready  = 1'b1;
	// Word-aligned byte address, register index above the lane bits
	assign reg_idx = paddr[`PAP_ADDR_HI:`PAP_IDX_LO];
	assign word_ok = (paddr[`PAP_IDX_LO-1:0] == '0);
	assign addr_ok = word_ok && ((reg_idx == `PAP_OFF_LATCH) || (reg_idx == `PAP_OFF_DIR)
		|| (reg_idx == `PAP_OFF_CMP_CTRL) || (reg_idx == `PAP_OFF_VREF_CTRL)
		|| (reg_idx == `PAP_OFF_CONFIG));
	assign pslverr = psel & penable & ~addr_ok;
	assign wr_en   = psel & penable & pwrite & pstrb[0] & addr_ok;
	assign rd_en   = psel & ~penable & ~pwrite;

	// Write loads the write data unchanged, without merging pin levels
	always_comb begin
		nxt_latch = pwdata[PORT_WIDTH-1:0];
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_port_latch_ff <= '0;
		end else if (!por_n) begin
			first_port_latch_ff[`PAP_LATCH_CLR_HI:0] <= `PAP_RST_LATCH_LO;
		end else if (wr_en && reg_idx == `PAP_OFF_LATCH) begin
			first_port_latch_ff <= nxt_latch;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			first_port_direction_ff <= `PAP_RST_DIR;
		end else if (!por_n) begin
			first_port_direction_ff <= `PAP_RST_DIR;
		end else if (wr_en && reg_idx == `PAP_OFF_DIR) begin
			first_port_direction_ff <= pwdata[PORT_WIDTH-1:0];
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cmp_ctrl_ff <= `PAP_RST_CTRL;
		end else if (!por_n) begin
			cmp_ctrl_ff <= `PAP_RST_CTRL;
		end else begin
			cmp_ctrl_ff[`PAP_CMP2_OUT] <= cmp2_result;
			cmp_ctrl_ff[`PAP_CMP1_OUT] <= cmp1_result;
			if (wr_en && reg_idx == `PAP_OFF_CMP_CTRL) begin
				cmp_ctrl_ff[`PAP_CMP_WR_HI:0] <= pwdata[`PAP_CMP_WR_HI:0];
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			vref_ctrl_ff <= `PAP_RST_CTRL;
		end else if (!por_n) begin
			vref_ctrl_ff <= `PAP_RST_CTRL;
		end else if (wr_en && reg_idx == `PAP_OFF_VREF_CTRL) begin
			vref_ctrl_ff <= pwdata[PORT_WIDTH-1:0] & `PAP_VREF_RSVD_MSK;
		end
	end

	// Device configuration; survives warm resets
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			config_ff <= `PAP_RST_CTRL;
		end else if (wr_en && reg_idx == `PAP_OFF_CONFIG) begin
			config_ff <= pwdata[PORT_WIDTH-1:0] & `PAP_CFG_MASK;
		end
	end

	// Read data captured in setup phase
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_ff <= 32'h0;
		end else if (rd_en) begin
			case (reg_idx)
				`PAP_OFF_LATCH:     prdata_ff <= {24'h0, pin_read};
				`PAP_OFF_DIR:       prdata_ff <= {24'h0, first_port_direction_ff};
				`PAP_OFF_CMP_CTRL:  prdata_ff <= {24'h0, cmp_ctrl_ff};
				`PAP_OFF_VREF_CTRL: prdata_ff <= {24'h0, vref_ctrl_ff};
				`PAP_OFF_CONFIG:    prdata_ff <= {24'h0, config_ff};
				default:            prdata_ff <= 32'h0;
			endcase
		end
	end

	assign prdata             = prdata_ff;
	assign comparator_control = cmp_ctrl_ff;
	assign vref_control       = vref_ctrl_ff;
endmodule : pap_port

/* File: testbench/pap_port_assertions.sv */
// Port-level checker for the first port
`timescale 1ns/1ps
module pap_port_assertions #(
	parameter int PORT_WIDTH = 8
) (
	input wire logic                  sys_clk,
	input wire logic                  rst_n,
	input wire logic                  por_n,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [11:0]           paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [3:0]            pstrb,
	input wire logic [31:0]           prdata,
	input wire logic                  pslverr,
	input wire logic [PORT_WIDTH-1:0] pad_in,
	input wire logic [PORT_WIDTH-1:0] pad_out,
	input wire logic [PORT_WIDTH-1:0] pad_oe_n,
	input wire logic                  master_clear_req,
	input wire logic                  timer0_ext_clock,
	input wire logic [PORT_WIDTH-1:0] comparator_control,
	input wire logic [PORT_WIDTH-1:0] vref_control
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_cmp_wr;
		s_access ##0 pwrite && pstrb[0] && paddr == 12'h07c && por_n;
	endsequence
	property p_od; pad_oe_n[4] == 1'b0 |-> pad_out[4] == 1'b0; endproperty
	property p_in_only; pad_oe_n[5] == 1'b1; endproperty
	property p_master_clear_in; master_clear_req |-> !pad_in[5]; endproperty
	property p_t0; timer0_ext_clock == pad_in[4]; endproperty
	property p_vref4; vref_control[4] == 1'b0; endproperty
	property p_por;
		!por_n |=> comparator_control == 8'h00 && vref_control == 8'h00 && pad_oe_n[5:0] == 6'h3f;
	endproperty
	property p_err;
		s_access |-> pslverr == !(paddr inside {12'h014, 12'h07c, 12'h214, 12'h27c, 12'h300});
	endproperty
	property p_upper; s_access |-> prdata[31:8] == 24'h000000; endproperty
	property p_cmp; s_cmp_wr |=> comparator_control[5:0] == $past(pwdata[5:0]); endproperty
	a_od: assert property (p_od) else $error("pin 4 driven high");
	a_in_only: assert property (p_in_only) else $error("pin 5 driven");
	a_master_clear_in: assert property (p_master_clear_in) else $error("clear without low pin");
	a_t0: assert property (p_t0) else $error("timer clock not pin 4");
	a_vref4: assert property (p_vref4) else $error("vref bit 4 set");
	a_por: assert property (p_por) else $error("warm reset values wrong");
	a_err: assert property (p_err) else $error("slave error wrong");
	a_upper: assert property (p_upper) else $error("upper read bits set");
	a_cmp: assert property (p_cmp) else $error("comparator write lost");
endmodule : pap_port_assertions

bind pap_port pap_port_assertions #(.PORT_WIDTH(PORT_WIDTH)) u_chk (
	.sys_clk           (sys_clk),
	.rst_n             (rst_n),
	.por_n             (por_n),
	.psel              (psel),
	.penable           (penable),
	.pwrite            (pwrite),
	.paddr             (paddr),
	.pwdata            (pwdata),
	.pstrb             (pstrb),
	.prdata            (prdata),
	.pslverr           (pslverr),
	.pad_in            (pad_in),
	.pad_out           (pad_out),
	.pad_oe_n          (pad_oe_n),
	.master_clear_req  (master_clear_req),
	.timer0_ext_clock  (timer0_ext_clock),
	.comparator_control(comparator_control),
	.vref_control      (vref_control)
);

/* File: testbench/pap_port_tb_top.sv */
// Self-checking bench for the first port
`timescale 1ns/1ps
module pap_port_tb_top;
	logic        sys_clk = 1'b0, rst_n = 1'b0, por_n = 1'b1, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, cmp1_result = 1'b0, cmp2_result = 1'b0, err;
	logic [7:0]  pad_in = 8'h00;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, rd;
	logic [3:0]  pstrb = 4'hf;
	logic        pready, pslverr, master_clear_req, timer0_ext_clock;
	logic [31:0] prdata;
	logic [7:0]  pad_out, pad_oe_n, comparator_control, vref_control;
	int          bad_count = 0, compares = 0, cyc = 0, n;
	always #5 sys_clk = ~sys_clk;
	pap_port #(.PORT_WIDTH(8)) dut (
		.sys_clk           (sys_clk),
		.rst_n             (rst_n),
		.por_n             (por_n),
		.psel              (psel),
		.penable           (penable),
		.pwrite            (pwrite),
		.paddr             (paddr),
		.pwdata            (pwdata),
		.pstrb             (pstrb),
		.prdata            (prdata),
		.pready            (pready),
		.pslverr           (pslverr),
		.pad_in            (pad_in),
		.pad_out           (pad_out),
		.pad_oe_n          (pad_oe_n),
		.cmp1_result       (cmp1_result),
		.cmp2_result       (cmp2_result),
		.master_clear_req  (master_clear_req),
		.timer0_ext_clock  (timer0_ext_clock),
		.comparator_control(comparator_control),
		.vref_control      (vref_control)
	);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		do @(posedge sys_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	// Transitions of the oscillator output pin over eight cycles
	task edges(output int cnt);
		logic p;
		cnt = 0;
		@(negedge sys_clk);
		p = pad_out[6];
		repeat (8) begin
			@(negedge sys_clk);
			if (pad_out[6] !== p) cnt++;
			p = pad_out[6];
		end
	endtask : edges
	task final_report;
		$display("mismatches %0d compares %0d", bad_count, compares);
		if (bad_count == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : final_report
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		xfer(1'b0, 12'h214, 32'h0);
		chk(rd, 32'hff);
		xfer(1'b0, 12'h27c, 32'h0);
		chk(rd, 32'h00);
		for (int m = 0; m < 4; m++) begin
			xfer(1'b1, 12'h300, 32'(m * 2));
			edges(n);
			chk(n, (m < 2) ? 4 : 0);
			chk(pad_oe_n[6], m >= 2);
		end
		@(posedge sys_clk);
		pad_in <= 8'h5a;
		xfer(1'b0, 12'h014, 32'h0);
		chk(rd, 32'h1a);
		xfer(1'b1, 12'h214, 32'h0);
		@(negedge sys_clk);
		chk(pad_oe_n, 8'he0);
		xfer(1'b1, 12'h014, 32'h1f);
		@(negedge sys_clk);
		chk(pad_oe_n, 8'hf0);
		chk(pad_out[4:0], 5'h0f);
		xfer(1'b1, 12'h07c, 32'hff);
		xfer(1'b0, 12'h07c, 32'h0);
		chk(rd, 32'h3f);
		xfer(1'b1, 12'h27c, 32'hff);
		xfer(1'b0, 12'h27c, 32'h0);
		chk(rd, 32'hef);
		por_n <= 1'b0;
		@(posedge sys_clk);
		por_n <= 1'b1;
		xfer(1'b1, 12'h214, 32'h0);
		@(negedge sys_clk);
		chk(pad_oe_n, 8'hf0);
		chk(pad_out[3:0], 4'h0);
		@(posedge sys_clk);
		cmp1_result <= 1'b1;
		cmp2_result <= 1'b1;
		xfer(1'b0, 12'h07c, 32'h0);
		chk(rd, 32'hc0);
		// Comparator output mode drives pins 3 and 4 from the results
		xfer(1'b1, 12'h07c, 32'h06);
		@(negedge sys_clk);
		chk({pad_oe_n[4], pad_out[3]}, 2'b11);
		@(posedge sys_clk);
		cmp1_result <= 1'b0;
		cmp2_result <= 1'b0;
		@(posedge sys_clk);
		@(negedge sys_clk);
		chk({pad_oe_n[4], pad_out[4:3]}, 3'b000);
		xfer(1'b1, 12'h300, 32'h07);
		pad_in <= 8'h00;
		@(posedge sys_clk);
		chk(master_clear_req, 1'b1);
		pad_in <= 8'h20;
		@(posedge sys_clk);
		chk(master_clear_req, 1'b0);
		xfer(1'b1, 12'h300, 32'h06);
		pad_in <= 8'h00;
		@(posedge sys_clk);
		chk(master_clear_req, 1'b0);
		xfer(1'b0, 12'h110, 32'h0);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		final_report();
	end
endmodule : pap_port_tb_top
